// [rtl/tbm_defs.svh]
// Purpose: field positions, limits and codes of the texture block mode decoder
// Assumes: included by the infill step and the mode decoder, which need the names; the package does not include it
// Notes: definitions only
`ifndef TBM_DEFS_SVH
`define TBM_DEFS_SVH
// block layout
`define TBM_BLK_W 128
`define TBM_MODE_HI 10
`define TBM_MODE_LO 0
`define TBM_PART_HI 12
`define TBM_PART_LO 11
`define TBM_EPM1_HI 16
`define TBM_EPM1_LO 13
`define TBM_PAT_HI 22
`define TBM_PAT_LO 13
`define TBM_EPM6_HI 28
`define TBM_EPM6_LO 23
`define TBM_CEMSEL_HI 24
`define TBM_CEMSEL_LO 23
// mode codes and limits
`define TBM_VOID_CODE 9'h1fc
`define TBM_FOUR_PARTS 2'h3
`define TBM_MAX_IDX 9'h040
`define TBM_MIN_SEQ 12'h018
`define TBM_MAX_SEQ 12'h060
`define TBM_BLK_BITS 12'h080
`define TBM_CHAN_W 12'h002
`define TBM_WGT_MAX 7'h40
`define TBM_INFILL_NUM 11'h400
`define TBM_INFILL_RND 14'h0020
`endif

// [rtl/tbm_pkg.sv]
// Purpose: types shared by the texture block mode decoder files
// Assumes: tbm_defs.svh holds the numeric names
// Notes: no constants live here, only types
package tbm_pkg;

	// grid and range decoded from the 11-bit index mode
	typedef struct packed {
		logic [3:0] n;
		logic [3:0] m;
		logic [3:0] q;
		logic dual;
		logic high;
		logic [2:0] rng;
		logic void_ext;
		logic reserved;
	} tbm_grid_type;

	// range code expanded to its maximum and its trit/quint/bit counts
	typedef struct packed {
		logic [4:0] max;
		logic trit;
		logic quint;
		logic [2:0] bits;
		logic valid;
	} tbm_range_type;

	// decoded block parameters handed downstream
	typedef struct packed {
		logic [2:0] part_cnt;
		logic [9:0] pattern;
		logic [5:0] endpoint_mode_field;
		logic [3:0] grid_n;
		logic [3:0] grid_m;
		logic [3:0] grid_q;
		tbm_range_type rng;
		logic dual;
		logic [1:0] second_plane_channel;
		logic [3:0] plane1_mask;
		logic [3:0] plane2_mask;
		logic [8:0] num_idx;
		logic [11:0] idx_bits;
	} tbm_params_type;

	// outcome flags
	typedef struct packed {
		logic err_color;
		logic nan_result;
		logic void_ext;
	} tbm_flags_type;

	// per-axis infill answer: grid index and sixteenths toward the next one
	typedef struct packed {
		logic [3:0] idx;
		logic [3:0] frac;
	} tbm_infill_type;

endpackage

// [rtl/tbm_infill_step.sv]
// Purpose: one axis of the index infill, texel coordinate to grid index and weight
// Assumes: footprint 1..12, grid 1..12, coordinate below footprint
// Notes: combinational; the caller registers the result
`timescale 1ns/10ps
`include "tbm_defs.svh"

module tbm_infill_step (
	// axis geometry
	input wire logic [3:0] foot_i,
	input wire logic [3:0] grid_i,
	// texel position on this axis
	input wire logic [3:0] coord_i,
	// answer
	output tbm_pkg::tbm_infill_type infill_o
);

	logic [10:0] ds;
	logic [13:0] cs;
	logic [13:0] gs;

	// texel 0 maps to 0 and ds scales texel foot-1 to cs 16; the second shift by 6 keeps idx at 0, frac at most 3
	always_comb begin
		ds = 11'h000;
		if (foot_i > 4'h1) begin
			ds = 11'((`TBM_INFILL_NUM + 11'(foot_i >> 1)) / 11'(foot_i - 4'h1));
		end
		cs = 14'(({3'h0, ds} * {10'h000, coord_i} + 14'h0020) >> 6);
		gs = 14'((cs * {10'h000, grid_i - 4'h1} + `TBM_INFILL_RND) >> 6);
		infill_o.idx = gs[7:4];
		infill_o.frac = gs[3:0];
	end

endmodule

// [rtl/tbm_mode_decoder.sv]
// Purpose: decode configuration fields of a 128-bit compressed texture block
// Assumes: block, footprint and queries come from logic on clk_i, no crossing
// Notes: one register stage for the block, one for each weight query
// Summary of operation
// - partition count minus one from bits 12:11, index mode from bits 10:0
// - single partition: endpoint mode field is bits 16:13
// - multi-partition: pattern selector 22:13, first six endpoint mode bits 28:23
// - dual plane with four partitions gives the error color
// - range code with precision bit gives max, trits, quints, bits; 000/001 invalid
// - 2D grid 2..12 with depth 1, 3D grid 2..5 per axis
// - grid larger than footprint on any axis gives the error color
// - dual-plane bit set means two index planes, except where bits 10:9 hold a grid size
// - 2D with mode bits 1:0 nonzero: five layouts from bits 3:2 and 8
// - 2D with mode bits 1:0 zero: 12xA+2, A+2x12, 6x10, 10x6, A+6xB+6
// - low nine bits 111111100 is void extent, other 8:6 ones with bits 1:0 zero 2D reserved
// - mode low four bits zero is reserved and yields NaN
// - 3D grids A+2 x B+2 x C+2 and the fixed-six variants
// - 3D with bits 1:0 zero: bits 8:5 all ones reserved unless 4:2 all ones, then void extent
// - at most 64 indices counting both planes, sequence 24 to 96 bits
// - limit violations yield NaN
// - index sequence read bit-reversed from block bit 127 down
// - each index rescaled to 0..64 as interpolation weight
// - two planes: 2-bit channel selector below index bits or leftover mode bits
// - indices alternate planes; plane one three channels, plane two the chosen one
// - infill leaves every texel at grid index 0, per-axis weights 0..3 sixteenths
`timescale 1ns/10ps
`include "tbm_defs.svh"

module tbm_mode_decoder #(
	parameter int BLK_W = `TBM_BLK_W
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// fetched block from the sampler pipeline
	input wire logic blk_valid_i,
	input wire logic [BLK_W-1:0] blk_data_i,
	input wire logic blk_is_3d_i,
	input wire logic [3:0] foot_w_i,
	input wire logic [3:0] foot_h_i,
	input wire logic [3:0] foot_d_i,
	// weight query against the held block
	input wire logic wgt_valid_i,
	input wire logic [4:0] wgt_raw_i,
	input wire logic [8:0] wgt_pos_i,
	input wire logic [3:0] texel_x_i,
	input wire logic [3:0] texel_y_i,
	input wire logic [3:0] texel_z_i,
	// decoded block
	output logic dec_valid_o,
	output tbm_pkg::tbm_params_type params_o,
	output tbm_pkg::tbm_flags_type flags_o,
	output logic [BLK_W-1:0] idx_seq_o,
	// weight answer
	output logic wgt_valid_o,
	output logic [6:0] wgt_o,
	output logic wgt_plane_o,
	output tbm_pkg::tbm_infill_type infill_x_o,
	output tbm_pkg::tbm_infill_type infill_y_o,
	output tbm_pkg::tbm_infill_type infill_z_o
);

	////////////////////////////////////////////////////////////////////////////////
	// decoding functions
	// 2-bit field plus offset as a 4-bit grid size
	function automatic logic [3:0] add2(input logic [1:0] f, input logic [3:0] off);
		add2 = {2'h0, f} + off;
	endfunction

	// index mode to grid size, range code and special cases
	function automatic tbm_pkg::tbm_grid_type mode_dec(input logic [10:0] m, input logic d3);
		tbm_pkg::tbm_grid_type g;
		g = '0;
		g.dual = m[10];
		g.high = m[9];
		g.q = 4'h1;
		g.rng = (m[1:0] != 2'h0) ? {m[1:0], m[4]} : {m[3:2], m[4]};
		if (m[3:0] == 4'h0) begin
			g.reserved = 1'b1;
		end else if (m[8:0] == `TBM_VOID_CODE) begin
			g.void_ext = 1'b1;
		end else if (!d3 && m[1:0] != 2'h0) begin
			unique case (m[3:2])
				2'h0: {g.n, g.m} = {add2(m[8:7], 4'h4), add2(m[6:5], 4'h2)};
				2'h1: {g.n, g.m} = {add2(m[8:7], 4'h8), add2(m[6:5], 4'h2)};
				2'h2: {g.n, g.m} = {add2(m[6:5], 4'h2), add2(m[8:7], 4'h8)};
				2'h3: begin
					if (!m[8]) begin
						{g.n, g.m} = {add2(m[6:5], 4'h2), add2({1'b0, m[7]}, 4'h6)};
					end else begin
						{g.n, g.m} = {add2({1'b0, m[7]}, 4'h2), add2(m[6:5], 4'h2)};
					end
				end
			endcase
		end else if (!d3) begin
			unique case (m[8:7])
				2'h0: {g.n, g.m} = {4'hc, add2(m[6:5], 4'h2)};
				2'h1: {g.n, g.m} = {add2(m[6:5], 4'h2), 4'hc};
				2'h2: {g.n, g.m, g.dual, g.high}
					= {add2(m[6:5], 4'h6), add2(m[10:9], 4'h6), 2'h0};
				2'h3: begin
					if (m[6]) begin
						g.reserved = 1'b1;
					end else begin
						{g.n, g.m} = m[5] ? 8'ha6 : 8'h6a;
					end
				end
			endcase
		end else if (m[1:0] != 2'h0) begin
			g.n = add2(m[6:5], 4'h2);
			g.m = add2(m[8:7], 4'h2);
			g.q = add2(m[3:2], 4'h2);
		end else begin
			unique case (m[8:7])
				2'h0: {g.n, g.m, g.q, g.dual, g.high}
					= {4'h6, add2(m[10:9], 4'h2), add2(m[6:5], 4'h2), 2'h0};
				2'h1: {g.n, g.m, g.q, g.dual, g.high}
					= {add2(m[6:5], 4'h2), 4'h6, add2(m[10:9], 4'h2), 2'h0};
				2'h2: {g.n, g.m, g.q, g.dual, g.high}
					= {add2(m[6:5], 4'h2), add2(m[10:9], 4'h2), 4'h6, 2'h0};
				2'h3: begin
					{g.n, g.m, g.q} = 12'h222;
					unique case (m[6:5])
						2'h0: g.n = 4'h6;
						2'h1: g.m = 4'h6;
						2'h2: g.q = 4'h6;
						2'h3: g.reserved = 1'b1;
					endcase
				end
			endcase
		end
		mode_dec = g;
	endfunction

	// precision bit and range code to the range description
	function automatic tbm_pkg::tbm_range_type range_dec(input logic h, input logic [2:0] r);
		tbm_pkg::tbm_range_type x;
		x = '0;
		x.valid = (r[2:1] != 2'h0);
		unique case ({h, r})
			4'h2: begin x.max = 5'h01; x.bits = 3'h1; end
			4'h3: begin x.max = 5'h02; x.trit = 1'b1; end
			4'h4: begin x.max = 5'h03; x.bits = 3'h2; end
			4'h5: begin x.max = 5'h04; x.quint = 1'b1; end
			4'h6: begin x.max = 5'h05; x.trit = 1'b1; x.bits = 3'h1; end
			4'h7: begin x.max = 5'h07; x.bits = 3'h3; end
			4'ha: begin x.max = 5'h09; x.quint = 1'b1; x.bits = 3'h1; end
			4'hb: begin x.max = 5'h0b; x.trit = 1'b1; x.bits = 3'h2; end
			4'hc: begin x.max = 5'h0f; x.bits = 3'h4; end
			4'hd: begin x.max = 5'h13; x.quint = 1'b1; x.bits = 3'h2; end
			4'he: begin x.max = 5'h17; x.trit = 1'b1; x.bits = 3'h3; end
			4'hf: begin x.max = 5'h1f; x.bits = 3'h5; end
			default: x.max = 5'h00; // codes 000 and 001 carry no range
		endcase
		range_dec = x;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// block decode, combinational

	tbm_pkg::tbm_grid_type grid;
	tbm_pkg::tbm_params_type par_nxt;
	tbm_pkg::tbm_flags_type flg_nxt;
	logic [1:0] part_m1;
	logic [8:0] cells;
	logic [11:0] n12;
	logic [11:0] extra;
	logic [11:0] chan_pos;
	logic big_grid;
	logic limit_bad;

	always_comb begin
		part_m1 = blk_data_i[`TBM_PART_HI:`TBM_PART_LO];
		grid = mode_dec(blk_data_i[`TBM_MODE_HI:`TBM_MODE_LO], blk_is_3d_i);
		par_nxt = '0;
		par_nxt.part_cnt = {1'b0, part_m1} + 3'h1;
		if (part_m1 == 2'h0) begin
			par_nxt.endpoint_mode_field = {2'h0, blk_data_i[`TBM_EPM1_HI:`TBM_EPM1_LO]};
		end else begin
			par_nxt.pattern = blk_data_i[`TBM_PAT_HI:`TBM_PAT_LO];
			par_nxt.endpoint_mode_field = blk_data_i[`TBM_EPM6_HI:`TBM_EPM6_LO];
		end
		par_nxt.grid_n = grid.n;
		par_nxt.grid_m = grid.m;
		par_nxt.grid_q = grid.q;
		par_nxt.rng = range_dec(grid.high, grid.rng);
		par_nxt.dual = grid.dual;
		// index count, doubled for two planes
		cells = 9'({5'h00, grid.n} * {5'h00, grid.m} * {5'h00, grid.q});
		par_nxt.num_idx = grid.dual ? 9'(cells << 1) : cells;
		n12 = {3'h0, par_nxt.num_idx};
		par_nxt.idx_bits = 12'((n12 * 12'h008 * {11'h000, par_nxt.rng.trit}) / 12'h005)
			+ 12'((n12 * 12'h007 * {11'h000, par_nxt.rng.quint}) / 12'h003)
			+ 12'(n12 * {9'h000, par_nxt.rng.bits});
		// leftover endpoint mode bits sit right under the index bits
		extra = 12'h000;
		if (part_m1 != 2'h0 && blk_data_i[`TBM_CEMSEL_HI:`TBM_CEMSEL_LO] != 2'h0) begin
			unique case (part_m1)
				2'h1: extra = 12'h002;
				2'h2: extra = 12'h005;
				default: extra = 12'h008;
			endcase
		end
		chan_pos = `TBM_BLK_BITS - par_nxt.idx_bits - extra - `TBM_CHAN_W;
		if (grid.dual && par_nxt.idx_bits <= `TBM_MAX_SEQ) begin
			par_nxt.second_plane_channel = blk_data_i[chan_pos[6:0] +: 2];
		end
		// channel masks, bit 0 red up to bit 3 alpha
		par_nxt.plane2_mask = 4'h0;
		par_nxt.plane1_mask = 4'hf;
		if (grid.dual) begin
			par_nxt.plane2_mask = 4'h1 << par_nxt.second_plane_channel;
			par_nxt.plane1_mask = ~par_nxt.plane2_mask;
		end
		// grid must fit the footprint and its own dimension range
		big_grid = (grid.n > foot_w_i) || (grid.m > foot_h_i)
			|| (blk_is_3d_i && grid.q > foot_d_i);
		if (blk_is_3d_i) begin
			big_grid = big_grid || grid.n > 4'h5 || grid.m > 4'h5 || grid.q > 4'h5;
		end else begin
			big_grid = big_grid || grid.n > 4'hc || grid.m > 4'hc || grid.q != 4'h1;
		end
		limit_bad = (par_nxt.num_idx > `TBM_MAX_IDX) || (par_nxt.idx_bits > `TBM_MAX_SEQ)
			|| (par_nxt.idx_bits < `TBM_MIN_SEQ) || !par_nxt.rng.valid;
		// void extent overrides, reserved and limit faults give NaN, then dual four-part or oversize grid gives error color
		flg_nxt = '0;
		if (grid.void_ext) begin
			flg_nxt.void_ext = 1'b1;
		end else if (grid.reserved || limit_bad) begin
			flg_nxt.nan_result = 1'b1;
		end else if ((grid.dual && part_m1 == `TBM_FOUR_PARTS) || big_grid) begin
			flg_nxt.err_color = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// bit reversal of the block, index data then starts at bit 0

	logic [BLK_W-1:0] rev;
	genvar gi;
	generate
		for (gi = 0; gi < BLK_W; gi++) begin : g_rev
			assign rev[gi] = blk_data_i[BLK_W-1-gi];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// block stage registers

	logic dec_valid_r, dec_valid_nxt;
	tbm_pkg::tbm_params_type par_r, par_hold_nxt;
	tbm_pkg::tbm_flags_type flg_r, flg_hold_nxt;
	logic [BLK_W-1:0] seq_r, seq_nxt;
	logic [3:0] fw_r, fw_nxt;
	logic [3:0] fh_r, fh_nxt;
	logic [3:0] fd_r, fd_nxt;

	// results hold until the next block so queries can refer to them
	always_comb begin
		dec_valid_nxt = blk_valid_i;
		par_hold_nxt = par_r;
		flg_hold_nxt = flg_r;
		seq_nxt = seq_r;
		fw_nxt = fw_r;
		fh_nxt = fh_r;
		fd_nxt = fd_r;
		if (blk_valid_i) begin
			par_hold_nxt = par_nxt;
			flg_hold_nxt = flg_nxt;
			seq_nxt = rev;
			fw_nxt = foot_w_i;
			fh_nxt = foot_h_i;
			fd_nxt = blk_is_3d_i ? foot_d_i : 4'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			dec_valid_r <= 1'b0;
			par_r <= '0;
			flg_r <= '0;
			seq_r <= '0;
			fw_r <= 4'h1;
			fh_r <= 4'h1;
			fd_r <= 4'h1;
		end else begin
			dec_valid_r <= dec_valid_nxt;
			par_r <= par_hold_nxt;
			flg_r <= flg_hold_nxt;
			seq_r <= seq_nxt;
			fw_r <= fw_nxt;
			fh_r <= fh_nxt;
			fd_r <= fd_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// weight query: rescale, plane choice and infill per axis

	tbm_pkg::tbm_infill_type inf_x, inf_y, inf_z;
	tbm_infill_step u_inf_x (.foot_i(fw_r), .grid_i(par_r.grid_n), .coord_i(texel_x_i),
		.infill_o(inf_x));
	tbm_infill_step u_inf_y (.foot_i(fh_r), .grid_i(par_r.grid_m), .coord_i(texel_y_i),
		.infill_o(inf_y));
	tbm_infill_step u_inf_z (.foot_i(fd_r), .grid_i(par_r.grid_q), .coord_i(texel_z_i),
		.infill_o(inf_z));

	logic wgt_valid_r, wgt_valid_nxt;
	logic [6:0] wgt_r, wgt_nxt;
	logic plane_r, plane_nxt;
	tbm_pkg::tbm_infill_type ix_r, ix_nxt, iy_r, iy_nxt, iz_r, iz_nxt;
	logic [10:0] num, quo;

	// divide rounds to nearest; a variable divisor trades area for covering all ranges
	always_comb begin
		wgt_valid_nxt = wgt_valid_i;
		wgt_nxt = wgt_r;
		plane_nxt = plane_r;
		ix_nxt = ix_r;
		iy_nxt = iy_r;
		iz_nxt = iz_r;
		num = 11'({6'h00, wgt_raw_i} * 11'h040 + 11'(par_r.rng.max >> 1));
		quo = 11'h000;
		if (wgt_valid_i) begin
			wgt_nxt = 7'h00;
			if (par_r.rng.max != 5'h00) begin
				// clamp on the full quotient, a cut one would wrap
				quo = num / {6'h00, par_r.rng.max};
				wgt_nxt = (quo > 11'(`TBM_WGT_MAX)) ? `TBM_WGT_MAX : 7'(quo);
			end
			plane_nxt = par_r.dual & wgt_pos_i[0];
			ix_nxt = inf_x;
			iy_nxt = inf_y;
			iz_nxt = inf_z;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wgt_valid_r <= 1'b0;
			wgt_r <= 7'h00;
			plane_r <= 1'b0;
			ix_r <= '0;
			iy_r <= '0;
			iz_r <= '0;
		end else begin
			wgt_valid_r <= wgt_valid_nxt;
			wgt_r <= wgt_nxt;
			plane_r <= plane_nxt;
			ix_r <= ix_nxt;
			iy_r <= iy_nxt;
			iz_r <= iz_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs
	assign dec_valid_o = dec_valid_r;
	assign params_o = par_r;
	assign flags_o = flg_r;
	assign idx_seq_o = seq_r;
	assign wgt_valid_o = wgt_valid_r;
	assign wgt_o = wgt_r;
	assign wgt_plane_o = plane_r;
	assign infill_x_o = ix_r;
	assign infill_y_o = iy_r;
	assign infill_z_o = iz_r;

endmodule

// [dv/tbm_mode_checker.sv]
// Purpose: port checks of the texture block mode decoder
// Assumes: one clock, srst_i synchronous active high
// Notes: bound to every tbm_mode_decoder instance
`timescale 1ns/10ps
module tbm_mode_checker #(
	parameter int BLK_W = 128
) (
	// clock and reset
	input logic clk_i,
	input logic srst_i,
	// block and query inputs
	input logic blk_valid_i,
	input logic [BLK_W-1:0] blk_data_i,
	input logic blk_is_3d_i,
	input logic [3:0] foot_w_i,
	input logic [3:0] foot_h_i,
	input logic [3:0] foot_d_i,
	input logic wgt_valid_i,
	input logic [8:0] wgt_pos_i,
	// decoder outputs
	input logic dec_valid_o,
	input tbm_pkg::tbm_params_type params_o,
	input tbm_pkg::tbm_flags_type flags_o,
	input logic [BLK_W-1:0] idx_seq_o,
	input logic wgt_valid_o,
	input logic [6:0] wgt_o,
	input logic wgt_plane_o
);
	default clocking dcb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);
	////////////////////////////////////////
	// field extraction, one cycle after the block is taken
	property p_dec; dec_valid_o == $past(blk_valid_i); endproperty
	a_dec: assert property (p_dec) else $error("block answer timing wrong");
	property p_part; blk_valid_i |=> params_o.part_cnt == $past(blk_data_i[12:11]) + 3'h1; endproperty
	a_part: assert property (p_part) else $error("partition count wrong");
	property p_one; blk_valid_i && blk_data_i[12:11] == 2'h0
		|=> params_o.endpoint_mode_field == {2'h0, $past(blk_data_i[16:13])}; endproperty
	a_one: assert property (p_one) else $error("single mode field wrong");
	property p_multi; blk_valid_i && blk_data_i[12:11] != 2'h0 |=> params_o.pattern ==
		$past(blk_data_i[22:13]) && params_o.endpoint_mode_field == $past(blk_data_i[28:23]);
	endproperty
	a_multi: assert property (p_multi) else $error("pattern or mode field wrong");
	property p_rev; blk_valid_i |=> idx_seq_o[0] == $past(blk_data_i[BLK_W-1])
		&& idx_seq_o[BLK_W-1] == $past(blk_data_i[0]); endproperty
	a_rev: assert property (p_rev) else $error("index sequence not reversed");
	////////////////////////////////////////
	// outcome flags; a bad block must never look clean
	property p_void; blk_valid_i && blk_data_i[8:0] == 9'h1fc |=> flags_o == 3'h1; endproperty
	a_void: assert property (p_void) else $error("void extent missed");
	property p_resv; blk_valid_i && blk_data_i[3:0] == 4'h0 |=> flags_o == 3'h2; endproperty
	a_resv: assert property (p_resv) else $error("reserved mode not nan");
	property p_dual4; dec_valid_o && params_o.dual && params_o.part_cnt == 3'h4
		|-> flags_o != 3'h0; endproperty
	a_dual4: assert property (p_dual4) else $error("dual plane with four parts clean");
	property p_fit; dec_valid_o && flags_o == 3'h0 |-> params_o.grid_n <= $past(foot_w_i)
		&& params_o.grid_m <= $past(foot_h_i)
		&& (!$past(blk_is_3d_i) || params_o.grid_q <= $past(foot_d_i)); endproperty
	a_fit: assert property (p_fit) else $error("clean block exceeds footprint");
	property p_lim; dec_valid_o && flags_o == 3'h0 |-> params_o.num_idx <= 9'h040
		&& params_o.idx_bits inside {[12'h018:12'h060]} && params_o.rng.valid; endproperty
	a_lim: assert property (p_lim) else $error("clean block breaks limits");
	property p_one_flag; $onehot0(flags_o); endproperty
	a_one_flag: assert property (p_one_flag) else $error("several flags set");
	////////////////////////////////////////
	// weight answer
	property p_wgt; wgt_valid_i |=> wgt_valid_o && wgt_o <= 7'h40; endproperty
	a_wgt: assert property (p_wgt) else $error("weight answer late or too big");
	property p_plane; wgt_valid_i
		|=> wgt_plane_o == ($past(params_o.dual) & $past(wgt_pos_i[0])); endproperty
	a_plane: assert property (p_plane) else $error("plane of weight wrong");
endmodule
bind tbm_mode_decoder tbm_mode_checker #(.BLK_W(BLK_W)) u_chk (.clk_i, .srst_i, .blk_valid_i,
	.blk_data_i, .blk_is_3d_i, .foot_w_i, .foot_h_i, .foot_d_i, .wgt_valid_i, .wgt_pos_i,
	.dec_valid_o, .params_o, .flags_o, .idx_seq_o, .wgt_valid_o, .wgt_o, .wgt_plane_o);

// [dv/tbm_sampler_model.sv]
// Purpose: sampler pipeline model that hands fetched blocks to the decoder
// Assumes: callers start each task 1 ns after a rising edge
// Notes: released data is inverted so stale values never pass for fresh ones
`timescale 1ns/10ps
module tbm_sampler_model (
	// clock
	input wire logic clk_i,
	// fetched block
	output logic blk_valid_o,
	output logic [127:0] blk_data_o,
	output logic blk_is_3d_o,
	output logic [11:0] foot_o
);
	// idle at time zero
	initial begin
		{blk_valid_o, blk_data_o, blk_is_3d_o} = '0;
		foot_o = 12'h441;
	end
	// one block, held across exactly one sampling edge
	task automatic send(input logic [127:0] d, input logic t3, input logic [11:0] ft);
		blk_valid_o = 1'b1;
		blk_data_o = d;
		blk_is_3d_o = t3;
		foot_o = ft;
		@(posedge clk_i);
		#1;
	endtask
	// release, then stall for gap cycles
	task automatic idle(input int gap);
		blk_valid_o = 1'b0;
		blk_data_o = ~blk_data_o;
		repeat (gap) begin
			@(posedge clk_i);
			#1;
		end
	endtask
endmodule

// [dv/tbm_mode_decoder_tb.sv]
// Purpose: self-checking bench of the texture block mode decoder
// Assumes: 200 MHz clock, inputs change 1 ns after each rising edge
// Notes: expectations come from bench functions only
`timescale 1ns/10ps
module tbm_mode_decoder_tb;
	// design signals
	logic clk_i, srst_i, blk_valid_i, blk_is_3d_i, wgt_valid_i;
	logic dec_valid_o, wgt_valid_o, wgt_plane_o;
	logic [127:0] blk_data_i, idx_seq_o;
	logic [11:0] foot;
	logic [4:0] wgt_raw_i;
	logic [8:0] wgt_pos_i;
	logic [3:0] texel_x_i, texel_y_i;
	logic [6:0] wgt_o;
	tbm_pkg::tbm_params_type params_o;
	tbm_pkg::tbm_flags_type flags_o;
	tbm_pkg::tbm_infill_type infill_x_o, infill_y_o;
	// expectation of the held block
	logic [3:0] e_n, e_m, e_q;
	logic e_d;
	logic [10:0] e_rng;
	logic [2:0] e_flags;
	logic [8:0] e_num;
	logic [11:0] e_bits;
	int errors, n_checks;
	// {max, trit, quint, bits} by {precision, range code}; zero marks invalid
	localparam logic [9:0] RTAB [16] = '{10'h0, 10'h0, 10'h021, 10'h050, 10'h062, 10'h088,
		10'h0b1, 10'h0e3, 10'h0, 10'h0, 10'h129, 10'h172, 10'h1e4, 10'h26a, 10'h2f3, 10'h3e5};
	localparam logic [25:0] CORNER [8] = '{{1'b0, 12'hcc1, 13'h01fc}, {1'b1, 12'h666, 13'h01fc},
		{1'b0, 12'hcc1, 13'h0010}, {1'b0, 12'hcc1, 13'h01c4}, {1'b0, 12'hcc1, 13'h1c22},
		{1'b0, 12'hcc1, 13'h1422}, {1'b0, 12'h331, 13'h0022}, {1'b1, 12'h555, 13'h0055}};
	////////////////////////////////////////
	tbm_sampler_model sm (.clk_i(clk_i), .blk_valid_o(blk_valid_i), .blk_data_o(blk_data_i),
		.blk_is_3d_o(blk_is_3d_i), .foot_o(foot));
	tbm_mode_decoder uut (.clk_i, .srst_i, .blk_valid_i, .blk_data_i, .blk_is_3d_i,
		.foot_w_i(foot[11:8]), .foot_h_i(foot[7:4]), .foot_d_i(foot[3:0]), .wgt_valid_i,
		.wgt_raw_i, .wgt_pos_i, .texel_x_i, .texel_y_i, .texel_z_i(4'h0), .dec_valid_o,
		.params_o, .flags_o, .idx_seq_o, .wgt_valid_o, .wgt_o, .wgt_plane_o, .infill_x_o,
		.infill_y_o, .infill_z_o());
	// 5 ns clock
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// mode decode as the bench reads it; 3D only for nonzero low bits or void
	task automatic expect_blk(input logic [127:0] b, input logic t3, input logic [11:0] ft);
		logic [10:0] md;
		logic [3:0] a, bb, hr;
		logic rs;
		md = b[10:0];
		a = {2'h0, md[6:5]};
		bb = {2'h0, md[8:7]};
		rs = md[3:0] == 4'h0;
		e_d = md[10];
		hr = {md[9], md[1:0], md[4]};
		e_q = 4'h1;
		if (t3) begin
			{e_n, e_m, e_q} = {a + 4'h2, bb + 4'h2, {2'h0, md[3:2]} + 4'h2};
		end else if (md[1:0] != 2'h0) begin
			case (md[3:2])
				2'h0: {e_n, e_m} = {bb + 4'h4, a + 4'h2};
				2'h1: {e_n, e_m} = {bb + 4'h8, a + 4'h2};
				2'h2: {e_n, e_m} = {a + 4'h2, bb + 4'h8};
				default: {e_n, e_m} = md[8] ? {md[7] + 4'h2, a + 4'h2} : {a + 4'h2, md[7] + 4'h6};
			endcase
		end else begin
			hr = {md[9], md[3:2], md[4]};
			rs = rs || md[8:6] == 3'h7;
			case (md[8:7])
				2'h0: {e_n, e_m} = {4'hc, a + 4'h2};
				2'h1: {e_n, e_m} = {a + 4'h2, 4'hc};
				2'h2: begin
					{e_n, e_m} = {a + 4'h6, {2'h0, md[10:9]} + 4'h6};
					e_d = 1'b0;
					hr[3] = 1'b0;
				end
				default: {e_n, e_m} = md[5] ? 8'ha6 : 8'h6a;
			endcase
		end
		e_rng = {RTAB[hr], RTAB[hr] != 10'h0};
		e_num = 9'(e_n * e_m * e_q * (e_d ? 2 : 1));
		e_bits = 12'(e_num * 8 * RTAB[hr][4] / 5 + e_num * 7 * RTAB[hr][3] / 3
			+ e_num * RTAB[hr][2:0]);
		e_flags = 3'h0;
		if (md[8:0] == 9'h1fc) e_flags = 3'h1;
		else if (rs || e_num > 64 || e_bits > 96 || e_bits < 24 || !e_rng[0]) e_flags = 3'h2;
		else if ((e_d && b[12:11] == 2'h3) || e_n > ft[11:8] || e_m > ft[7:4]
			|| (t3 && e_q > ft[3:0])) e_flags = 3'h4;
	endtask
	// send one block and compare its decode in the answer cycle
	task automatic blk(input logic [127:0] b, input logic t3, input logic [11:0] ft);
		logic [127:0] r;
		logic [1:0] ch;
		for (int i = 0; i < 128; i++) r[i] = b[127 - i];
		expect_blk(b, t3, ft);
		sm.send(b, t3, ft);
		chk("dec_valid", dec_valid_o, 1'b1);
		chk("part_cnt", params_o.part_cnt, b[12:11] + 3'h1);
		chk("mode_field", params_o.endpoint_mode_field, b[12:11] == 0 ? b[16:13] : b[28:23]);
		chk("pattern", params_o.pattern, b[12:11] == 2'h0 ? 10'h0 : b[22:13]);
		chk("idx_seq", idx_seq_o, r);
		chk("flags", flags_o, e_flags);
		if (e_flags == 3'h0) begin
			chk("grid", {params_o.grid_n, params_o.grid_m, params_o.grid_q}, {e_n, e_m, e_q});
			chk("range", params_o.rng, e_rng);
			chk("dual", params_o.dual, e_d);
			chk("count", {params_o.num_idx, params_o.idx_bits}, {e_num, e_bits});
			ch = e_d ? b[126 - e_bits +: 2] : 2'h0;
			if (b[12:11] == 2'h0 || !e_d) begin
				chk("channel", params_o.second_plane_channel, ch);
				chk("masks", {params_o.plane1_mask, params_o.plane2_mask},
					e_d ? {~(4'h1 << ch), 4'h1 << ch} : 8'hf0);
			end
		end
	endtask
	function automatic int exp_inf(input int ft, input int gr, input int c);
		int ds;
		ds = ft <= 1 ? 0 : (1024 + ft / 2) / (ft - 1);
		return ((((ds * c + 32) >> 6) * (gr - 1) + 32) >> 6) & 8'hff;
	endfunction
	// one weight query; valid stays up so queries may run back to back
	task automatic query(input logic [4:0] raw, input logic [4:0] mx);
		int w;
		wgt_valid_i = 1'b1;
		wgt_raw_i = raw;
		wgt_pos_i = 9'($urandom_range(63));
		texel_x_i = 4'($urandom_range(11));
		texel_y_i = 4'($urandom_range(11));
		w = (raw * 64 + mx / 2) / mx;
		@(posedge clk_i);
		#1;
		chk("wgt", {wgt_valid_o, wgt_o}, {1'b1, 7'(w > 64 ? 64 : w)});
		chk("plane", wgt_plane_o, e_d & wgt_pos_i[0]);
		chk("infill_x", infill_x_o, exp_inf(12, e_n, texel_x_i));
		chk("infill_y", infill_y_o, exp_inf(12, e_m, texel_y_i));
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// hang guard
	initial begin
		#400000;
		errors++;
		give_verdict();
	end
	////////////////////////////////////////
	// main sequence
	initial begin
		logic [127:0] b;
		logic [11:0] ft;
		logic [10:0] md;
		logic [4:0] mx;
		logic t3;
		{errors, n_checks} = '0;
		srst_i = 1'b1;
		{wgt_valid_i, wgt_raw_i, wgt_pos_i, texel_x_i, texel_y_i} = '0;
		void'($urandom(32'h51b91995));
		repeat (4) @(posedge clk_i);
		#1;
		srst_i = 1'b0;
		chk("reset", {dec_valid_o, flags_o, wgt_valid_o, wgt_o}, 0);
		// every range code in a clean block, weights at both ends and inside
		for (int hr = 2; hr < 16; hr++) begin
			if (RTAB[hr] == 10'h0) continue;
			for (int g = 0; g < 16; g++) begin
				md = {1'b0, hr[3], g[3:0], hr[0], 2'h0, hr[2:1]};
				b = {$urandom, $urandom, $urandom, $urandom};
				b[12:0] = {2'h0, md};
				expect_blk(b, 1'b0, 12'hcc1);
				if (e_flags == 3'h0) break;
			end
			blk(b, 1'b0, 12'hcc1);
			sm.idle(0);
			mx = RTAB[hr][9:5];
			query(5'h0, mx);
			query(mx, mx);
			query(5'($urandom_range(mx)), mx);
			wgt_valid_i = 1'b0;
		end
		$display("test ranges done");
		// random blocks of both kinds, back to back or with stalls
		for (int i = 0; i < 600; i++) begin
			b = {$urandom, $urandom, $urandom, $urandom};
			t3 = 1'($urandom);
			if (t3 && b[1:0] == 2'h0) b[1:0] = 2'h1;
			ft[11:8] = 4'($urandom_range(t3 ? 6 : 12, 2));
			ft[7:4] = 4'($urandom_range(t3 ? 6 : 12, 2));
			ft[3:0] = t3 ? 4'($urandom_range(6, 2)) : 4'h1;
			blk(b, t3, ft);
			if ($urandom_range(3) == 0) sm.idle($urandom_range(3) + 1);
		end
		$display("test random done");
		// void, reserved, dual with four and with three parts, grid over footprint, clean 3D
		foreach (CORNER[k]) begin
			b = {$urandom, $urandom, $urandom, $urandom};
			b[12:0] = CORNER[k][12:0];
			blk(b, CORNER[k][25], CORNER[k][24:13]);
		end
		$display("test corners done");
		// reset in mid-run clears the held answer
		sm.idle(1);
		srst_i = 1'b1;
		@(posedge clk_i);
		#1;
		srst_i = 1'b0;
		chk("mid_reset", {dec_valid_o, flags_o, params_o.part_cnt}, 0);
		$display("test reset done");
		give_verdict();
	end
endmodule
